// >>> tb_threshold_interrupt_regs.sv
// Self-checking bench for the limit and interrupt register block.
// Assumes the host model drives the register port; results come from here.
`timescale 1ns/1ps
`default_nettype none
module tb_threshold_interrupt_regs;
    import tir_pkg::*;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, bv = 1'b0, av = 1'b0, ce = 1'b1;
    logic ben = 1'b0, aen = 1'b0, len = 1'b0, sel = 1'b0, wr, rd, int_n;
    logic [7:0] addr, wdata, rdata, d, m;
    logic [2:0] dly, dt;
    logic [1:0] fq;
    tir_word_t res = 16'h0000, lo, hi, v;
    tir_flags_t ex;
    tir_byte_t lim [4];
    int seed = 93, fails = 0, num_checks = 0;
    // ----------------
    // Clock and units
    // ----------------
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    tir_host tir_host_inst (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata));
    tir_regs tir_regs_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .bio_valid_i(bv), .bio_result_i(res), .als_valid_i(av),
        .als_result_i(res), .bio_done_en_i(ben), .als_done_en_i(aen), .limit_en_i(len),
        .limit_source_select_i(sel), .int_n_o(int_n), .mod_delay_o(dly),
        .test_freq_o(fq), .dead_time_o(dt));
    // Compare and count
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Expected flags after one result
    function automatic tir_flags_t nxt(tir_flags_t f, logic bio, tir_word_t r);
        if (bio ? ben : aen) f[{1'b1, bio}] = 1'b1;
        if (len && bio != sel && r < lo) f[1] = 1'b1;
        if (len && bio != sel && r > hi) f[0] = 1'b1;
        return f;
    endfunction
    // One result strobe on one source
    task automatic ev(input logic bio, input tir_word_t r);
        @(negedge clk_sys_i);
        res = r;
        bv = bio;
        av = ~bio;
        @(negedge clk_sys_i);
        {bv, av} = 2'b00;
        res = ~r;
        ex = nxt(ex, bio, r);
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        ex = 4'h0;
        chk({dly, fq, dt}, 16'h0001);
        chk(int_n, 16'h0001);
        tir_host_inst.rd(8'h8f, d);
        chk(d, 16'h0001);
        tir_host_inst.rd(8'h89, d);
        chk(d, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            lim[i] = 8'($random(seed));
            tir_host_inst.wr(8'h8a + i[7:0], lim[i]);
        end
        for (int i = 0; i < 4; i++) begin
            tir_host_inst.rd(8'h8a + i[7:0], d);
            chk(d, lim[i]);
        end
        lo = {lim[0], lim[1]};
        hi = {lim[2], lim[3]};
        m = 8'($random(seed));
        tir_host_inst.wr(8'h8f, m);
        chk({dly, fq, dt}, m);
        tir_host_inst.wr(8'h8f, 8'h01);
        for (int i = 0; i < 60; i++) begin
            {ben, aen, len, sel} = 4'($random(seed));
            case (i % 5)
                0: v = lo;
                1: v = lo - 16'h0001;
                2: v = hi;
                3: v = hi + 16'h0001;
                default: v = 16'($random(seed));
            endcase
            ev(i[0], v);
            tir_host_inst.rd(8'h8e, d);
            chk(d, {4'h0, ex});
            chk(int_n, ~|ex);
            m = 8'($random(seed));
            tir_host_inst.wr(8'h8e, m);
            ex = ex & ~m[3:0];
        end
        // Result strobe and clear in one cycle: set wins
        ben = 1'b1;
        fork
            ev(1'b1, 16'h8000);
            tir_host_inst.wr(8'h8e, 8'h08);
        join
        tir_host_inst.rd(8'h8e, d);
        chk(d, {4'h0, ex});
        // Enable low freezes limits and flags
        ce = 1'b0;
        tir_host_inst.wr(8'h8a, ~lim[0]);
        tir_host_inst.wr(8'h8e, 8'h0f);
        ce = 1'b1;
        tir_host_inst.rd(8'h8a, d);
        chk(d, lim[0]);
        tir_host_inst.rd(8'h8e, d);
        chk(d, {4'h0, ex});
        chk(int_n, ~|ex);
        // Reset in mid-run brings back the defaults
        nrst_i = 1'b0;
        @(negedge clk_sys_i);
        nrst_i = 1'b1;
        ex = 4'h0;
        chk({dly, fq, dt}, 16'h0001);
        chk(int_n, 16'h0001);
        tir_host_inst.rd(8'h8e, d);
        chk(d, 16'h0000);
        tir_host_inst.rd(8'h8c, d);
        chk(d, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire

// >>> tir_host.sv
// Host model: drives the byte register port of the limit block.
// Assumes the bench clock; requests change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tir_host (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    // ----------------
    // Byte transfers
    // ----------------
    initial begin
        {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
    end
    // One write strobe, data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    // Read strobe; data taken one cycle on
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> tir_map.svh
// Register offsets, field positions and reset values of the limit block.
// Assumes inclusion by the single design file only; the package does not include it.
`ifndef TIR_MAP_SVH
`define TIR_MAP_SVH
`define TIR_ADDR_LOW_HI 8'h8a
`define TIR_ADDR_LOW_LO 8'h8b
`define TIR_ADDR_HIGH_HI 8'h8c
`define TIR_ADDR_HIGH_LO 8'h8d
`define TIR_ADDR_FLAGS 8'h8e
`define TIR_ADDR_MODT 8'h8f
`define TIR_ADDR_AMB_IR 8'h90
`define TIR_BIT_BIO_DONE 3
`define TIR_BIT_ALS_DONE 2
`define TIR_BIT_BELOW 1
`define TIR_BIT_ABOVE 0
`define TIR_MODT_RESET 8'h01
`define TIR_LIMIT_RESET 16'h0000
`define TIR_FLAGS_RESET 4'h0
`endif

// >>> tir_pkg.sv
// Types shared by the limit and interrupt register block.
// Assumes nothing beyond the map header.
`default_nettype none
package tir_pkg;
    typedef logic [7:0] tir_byte_t;
    typedef logic [15:0] tir_word_t;
    typedef logic [3:0] tir_flags_t;
endpackage
`default_nettype wire

// >>> tir_regs.sv
// Limit, interrupt flag and modulator timing registers of a light sensor.
// Assumes a register port decoded from the serial bus and result strobes on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
`include "tir_map.svh"

// Contract
// R1: Low limit is sixteen bits, high byte at 8Ah, low byte at 8Bh.
// R2: High limit is sixteen bits, high byte at 8Ch, low byte at 8Dh.
// R3: Status register at 8Eh holds four flags: two data ready, below, above.
// R4: Below flag sets when result under low limit; above when over high.
// R5: Flags stick at one; writing one clears, writing zero leaves them.
// R6: Interrupt pad low while any status flag is one.
// R7: Timing register at 8Fh: delay bits 7..5, frequency 4..3, dead time 2..0.
// R8: Delay field steers emitter to detector evaluation delay; resets to zero.
// R9: Dead time field steers edge dead time; resets to one.
// R10: Host should program timing register to one, its default.
// R11: Host leaves reserved register at 90h alone.
// R12: Source select picks biosensor results at zero, ambient at one.
// R13: Flags set only while their enable is on; enable changes keep flags.
module tir_regs
    import tir_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic bio_valid_i,
    input wire logic [15:0] bio_result_i,
    input wire logic als_valid_i,
    input wire logic [15:0] als_result_i,
    input wire logic bio_done_en_i,
    input wire logic als_done_en_i,
    input wire logic limit_en_i,
    input wire logic limit_source_select_i,
    output logic int_n_o,
    output logic [2:0] mod_delay_o,
    output logic [1:0] test_freq_o,
    output logic [2:0] dead_time_o
);

    tir_word_t low_limit_q, low_limit_d;
    tir_word_t high_limit_q, high_limit_d;
    tir_flags_t flags_q, flags_d;
    tir_byte_t modt_q, modt_d;
    tir_byte_t rdata_q, rdata_d;
    logic int_n_q, int_n_d;
    logic cmp_valid;
    tir_word_t cmp_value;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        low_limit_d = low_limit_q;
        high_limit_d = high_limit_q;
        modt_d = modt_q;
        flags_d = flags_q;
        rdata_d = rdata_q;
        // Compared source follows select
        cmp_valid = limit_source_select_i ? als_valid_i : bio_valid_i; // R12
        cmp_value = limit_source_select_i ? als_result_i : bio_result_i; // R12
        if (reg_wr_i) begin
            if (reg_addr_i == `TIR_ADDR_LOW_HI) begin
                low_limit_d[15:8] = reg_wdata_i; // R1
            end else if (reg_addr_i == `TIR_ADDR_LOW_LO) begin
                low_limit_d[7:0] = reg_wdata_i; // R1
            end else if (reg_addr_i == `TIR_ADDR_HIGH_HI) begin
                high_limit_d[15:8] = reg_wdata_i; // R2
            end else if (reg_addr_i == `TIR_ADDR_HIGH_LO) begin
                high_limit_d[7:0] = reg_wdata_i; // R2
            end else if (reg_addr_i == `TIR_ADDR_FLAGS) begin
                flags_d = flags_q & ~reg_wdata_i[3:0]; // R5
            end else if (reg_addr_i == `TIR_ADDR_MODT) begin
                modt_d = reg_wdata_i; // R7
            end
        end
        // Set wins over a same-cycle clear
        if (bio_valid_i && bio_done_en_i) begin
            flags_d[`TIR_BIT_BIO_DONE] = 1'b1; // R13
        end
        if (als_valid_i && als_done_en_i) begin
            flags_d[`TIR_BIT_ALS_DONE] = 1'b1; // R13
        end
        if (cmp_valid && limit_en_i && (cmp_value < low_limit_q)) begin
            flags_d[`TIR_BIT_BELOW] = 1'b1; // R4
        end
        if (cmp_valid && limit_en_i && (cmp_value > high_limit_q)) begin
            flags_d[`TIR_BIT_ABOVE] = 1'b1; // R4
        end
        int_n_d = ~(|flags_d); // R6
        // Read data; reserved and unmapped read zero
        if (reg_rd_i) begin
            if (reg_addr_i == `TIR_ADDR_LOW_HI) begin
                rdata_d = low_limit_q[15:8];
            end else if (reg_addr_i == `TIR_ADDR_LOW_LO) begin
                rdata_d = low_limit_q[7:0];
            end else if (reg_addr_i == `TIR_ADDR_HIGH_HI) begin
                rdata_d = high_limit_q[15:8];
            end else if (reg_addr_i == `TIR_ADDR_HIGH_LO) begin
                rdata_d = high_limit_q[7:0];
            end else if (reg_addr_i == `TIR_ADDR_FLAGS) begin
                rdata_d = {4'h0, flags_q}; // R3
            end else if (reg_addr_i == `TIR_ADDR_MODT) begin
                rdata_d = modt_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_limit_q <= `TIR_LIMIT_RESET;
            high_limit_q <= `TIR_LIMIT_RESET;
            flags_q <= `TIR_FLAGS_RESET;
            modt_q <= `TIR_MODT_RESET; // R8 R9
            rdata_q <= 8'h00;
            int_n_q <= 1'b1;
        end else if (ce_i) begin
            low_limit_q <= low_limit_d;
            high_limit_q <= high_limit_d;
            flags_q <= flags_d;
            modt_q <= modt_d;
            rdata_q <= rdata_d;
            int_n_q <= int_n_d;
        end
    end

    // Timing fields drive the modulator
    assign mod_delay_o = modt_q[7:5]; // R8
    assign test_freq_o = modt_q[4:3]; // R7
    assign dead_time_o = modt_q[2:0]; // R9
    assign reg_rdata_o = rdata_q;
    assign int_n_o = int_n_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_int_tracks;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ce_i |=> (int_n_o == ~(|flags_q));
    endproperty
    a_int_tracks: assert property (p_int_tracks) else $error("int pad not tracking flags"); // R6

    property p_w1c;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && reg_wr_i && reg_addr_i == 8'h8e && reg_wdata_i[3] && !bio_valid_i)
        |=> !flags_q[3];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by one"); // R5

    property p_w0_keeps;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && flags_q[1] && !(reg_wr_i && reg_addr_i == 8'h8e && reg_wdata_i[1]))
        |=> flags_q[1];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost without clear"); // R5

    property p_below;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && limit_en_i && !limit_source_select_i && bio_valid_i
         && bio_result_i < low_limit_q) |=> flags_q[1];
    endproperty
    a_below: assert property (p_below) else $error("below flag missed"); // R4

    property p_above_als;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && limit_en_i && limit_source_select_i && als_valid_i
         && als_result_i > high_limit_q) |=> flags_q[0];
    endproperty
    a_above_als: assert property (p_above_als) else $error("above flag missed"); // R12

    property p_no_set_disabled;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!flags_q[3] && !(bio_valid_i && bio_done_en_i)) |=> !flags_q[3];
    endproperty
    a_no_set_disabled: assert property (p_no_set_disabled) else $error("flag set while disabled"); // R13

    property p_low_write;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && reg_wr_i && reg_addr_i == 8'h8a) |=> low_limit_q[15:8] == $past(reg_wdata_i);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low limit high byte not written"); // R1

    property p_high_read;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && reg_rd_i && reg_addr_i == 8'h8d) |=> reg_rdata_o == $past(high_limit_q[7:0]);
    endproperty
    a_high_read: assert property (p_high_read) else $error("high limit low byte misread"); // R2

    property p_flag_read;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && reg_rd_i && reg_addr_i == 8'h8e) |=> reg_rdata_o == {4'h0, $past(flags_q)};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("status misread"); // R3

    property p_modt_fields;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && reg_wr_i && reg_addr_i == 8'h8f)
        |=> {mod_delay_o, test_freq_o, dead_time_o} == $past(reg_wdata_i);
    endproperty
    a_modt_fields: assert property (p_modt_fields) else $error("timing fields wrong"); // R7

    property p_als_done;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && als_valid_i && als_done_en_i) |=> flags_q[2];
    endproperty
    a_als_done: assert property (p_als_done) else $error("ambient ready flag missed"); // R13

    property p_high_write;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && reg_wr_i && reg_addr_i == 8'h8c) |=> high_limit_q[15:8] == $past(reg_wdata_i);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high limit high byte not written"); // R2

    // Enable low keeps every register and the pad as they were
    property p_ce_hold;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !ce_i |=> $stable(flags_q) && $stable(low_limit_q) && $stable(high_limit_q)
            && $stable(modt_q) && $stable(reg_rdata_o) && $stable(int_n_o);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved while enable low"); // R5

endmodule
`default_nettype wire
